// file: pkg/bank_regs_defs.svh
// Address map, field positions and reset values of the banked register file
`ifndef BANK_REGS_DEFS_SVH
`define BANK_REGS_DEFS_SVH
`define STATUS_WORD_ADDR 16'h003f
`define BANK_BASE_ADDR 16'h0040
`define BANK_LAST_ADDR 16'h00bf
`define BANK_SEL_RESET 4'h0
`define JF_BIT 7
`define ZF_BIT 6
`define CF_BIT 5
`define HF_BIT 4
`define REG_W 3'h0
`define REG_A 3'h1
`define REG_B 3'h2
`define REG_C 3'h3
`define REG_D 3'h4
`define REG_E 3'h5
`define REG_H 3'h6
`define REG_L 3'h7
`endif

// file: pkg/bank_regs_pkg.sv
// Types shared by the banked register file and its users
`default_nettype none
package bank_regs_pkg;
   // Register pair selector
   typedef enum logic [1:0] {
      pair_acc = 2'h0,
      pair_cnt = 2'h1,
      pair_ptr = 2'h2,
      pair_idx = 2'h3
   } pair_sel_t;
   // Index and pointer register address modes
   typedef enum logic [2:0] {
      idx_plain = 3'h0,
      idx_disp = 3'h1,
      idx_plus_c = 3'h2,
      idx_post_inc = 3'h3,
      idx_pre_dec = 3'h4,
      ptr_plain = 3'h5
   } addr_mode_t;
   // Flag update sources from execution
   typedef enum logic [3:0] {
      fl_none = 4'h0,
      fl_add8 = 4'h1,
      fl_sub8 = 4'h2,
      fl_add16 = 4'h3,
      fl_sub16 = 4'h4,
      fl_transfer = 4'h5,
      fl_bitop = 4'h6,
      fl_mul = 4'h7,
      fl_div = 4'h8,
      fl_shift = 4'h9,
      fl_cf_bool = 4'ha,
      fl_logic = 4'hb
   } flag_op_t;
   // Carry flag boolean accumulator operations
   typedef enum logic [2:0] {
      cb_load = 3'h0,
      cb_xor = 3'h1,
      cb_store = 3'h2,
      cb_set = 3'h3,
      cb_clear = 3'h4,
      cb_cpl = 3'h5
   } cf_op_t;
   // Jump conditions
   typedef enum logic [2:0] {
      jc_true = 3'h0,
      jc_false = 3'h1,
      jc_zero = 3'h2,
      jc_nzero = 3'h3,
      jc_carry = 3'h4,
      jc_ncarry = 3'h5
   } jump_cond_t;
   // Data memory port
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mem_req_t;
   // Register port, byte or pair
   typedef struct packed {
      logic wr8;
      logic [2:0] sel8;
      logic [7:0] d8;
      logic wr16;
      pair_sel_t sel16;
      logic [15:0] d16;
   } reg_req_t;
   // Flag update request
   typedef struct packed {
      flag_op_t op;
      logic [16:0] result;
      logic half_carry;
      logic bit_val;
      logic jf_from_carry;
      cf_op_t cf_op;
      logic set_jf;
   } flag_req_t;
   // Status word stack traffic
   typedef struct packed {
      logic irq_accept;
      logic ret_restore;
      logic [7:0] pop_data;
      logic ld_bank;
      logic [3:0] bank_imm;
   } psw_req_t;
endpackage
`default_nettype wire

// file: src/banked_regs_and_status_word.sv
// Banked general-purpose registers and program status word
// Functional notes
// - Sixteen banks of eight bytes at 0040-00BF.
// - Bytes also readable and writable as pairs.
// - Index pair pointer modes; pointer pair plain.
// - C divides accumulator pair; quotient low, remainder high.
// - Four-bit bank selector, reset to zero.
// - Status word at 003F, flags high nibble.
// - Memory write sets bank, jump flag only.
// - Status word reachable by bank load, push, pop.
// - Interrupt saves status word; returns restore it.
// - Reset sets jump flag, others keep.
// - Zero flag on zero byte or word result.
// - Bit ops: zero flag from old bit.
// - Multiply upper byte, divide remainder, set zero.
// - Carry from add carry or subtract borrow.
// - Divide carry on zero divisor or overflow.
// - Shifts load carry with bit out.
// - Carry flag acts as boolean accumulator.
// - Jumps test zero, carry, jump flag only.
// - Half carry from bit three boundary.
// - Jump flag from arithmetic, logic, bit and shift results; transfers set it to one.
// - Status word pushed first, popped last.
`include "bank_regs_defs.svh"
`default_nettype none
module banked_regs_and_status_word (
   input wire logic core_clk,
   input wire logic rst,
   input wire bank_regs_pkg::mem_req_t mem_req,
   output logic [7:0] mem_rdata,
   output logic mem_hit,
   input wire bank_regs_pkg::reg_req_t reg_req,
   input wire logic [2:0] rd_sel8,
   output logic [7:0] rd_data8,
   input wire bank_regs_pkg::pair_sel_t rd_sel16,
   output logic [15:0] rd_data16,
   input wire bank_regs_pkg::addr_mode_t addr_mode,
   input wire logic [7:0] disp,
   input wire logic addr_step,
   output logic [15:0] eff_addr,
   input wire logic div_go,
   output logic div_error,
   input wire bank_regs_pkg::flag_req_t flag_req,
   input wire bank_regs_pkg::psw_req_t psw_req,
   output logic [7:0] status_word,
   output logic [7:0] psw_push_data,
   output logic [3:0] bank_selector,
   input wire bank_regs_pkg::jump_cond_t jump_cond,
   output logic jump_taken
);
   import bank_regs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Storage
   // The array is the data memory window of the banks, so a
   // register and its memory alias are one and the same byte.
   // Flags live apart from the array; only the bank sits under them.
   logic [7:0] regs_q [0:127]; // All banks, byte addressed
   logic [3:0] bank_q; // Current bank
   logic jf_q; // Jump status
   logic zf_q; // Zero
   logic cf_q; // Carry
   logic hf_q; // Half carry
   logic [7:0] rdata_q; // Registered memory read data

   // Helpers shared by the register read and write paths
   // Bank number forms the upper index bits, register the lower
   // Byte index of a register within the current bank
   function automatic logic [6:0] cur_idx(input logic [3:0] bank, input logic [2:0] r);
      cur_idx = {bank, r};
   endfunction

   // Pair to high-byte register number
   // High byte sits at the even register, low at the next odd one
   function automatic logic [2:0] pair_hi(input pair_sel_t p);
      pair_hi = {p, 1'b0};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Memory decode
   // Both decodes are plain compares on the address, so mem_hit
   // is valid in the same cycle as the request.
   // Addresses outside the window are ignored on write and read as
   // zero; other blocks on the memory bus answer them.
   // The status word sits just below the first bank.
   wire in_banks = (mem_req.addr >= `BANK_BASE_ADDR) && (mem_req.addr <= `BANK_LAST_ADDR);
   wire is_psw = (mem_req.addr == `STATUS_WORD_ADDR);
   wire [15:0] bank_off = mem_req.addr - `BANK_BASE_ADDR;
   wire [6:0] mem_idx = bank_off[6:0];
   wire psw_mem_wr = mem_req.wr && is_psw;
   wire [7:0] flags_word = {jf_q, zf_q, cf_q, hf_q, bank_q};

   ////////////////////////////////////////////////////////////////////////
   // Register reads in the current bank
   // All reads are combinational against the current bank, so a
   // bank change takes effect for reads from the next cycle on.
   // The execution side must not rely on the old bank after a switch.
   wire [7:0] pair_hi_b = regs_q[cur_idx(bank_q, pair_hi(rd_sel16))];
   wire [7:0] pair_lo_b = regs_q[cur_idx(bank_q, pair_hi(rd_sel16) + 3'h1)];
   wire [15:0] idx_pair = {regs_q[cur_idx(bank_q, `REG_H)], regs_q[cur_idx(bank_q, `REG_L)]};
   wire [15:0] ptr_pair = {regs_q[cur_idx(bank_q, `REG_D)], regs_q[cur_idx(bank_q, `REG_E)]};
   wire [7:0] reg_c = regs_q[cur_idx(bank_q, `REG_C)];
   wire [15:0] acc_pair = {regs_q[cur_idx(bank_q, `REG_W)], regs_q[cur_idx(bank_q, `REG_A)]};

   assign rd_data8 = regs_q[cur_idx(bank_q, rd_sel8)];
   assign rd_data16 = {pair_hi_b, pair_lo_b};

   ////////////////////////////////////////////////////////////////////////
   // Effective address for pointer modes
   // Pre-decrement shows the lowered pointer at once; the step
   // pulse then writes the same value back into the index pair.
   // Post-increment shows the pointer before the step.
   wire [15:0] idx_dec = idx_pair - 16'h0001;
   wire [15:0] idx_inc = idx_pair + 16'h0001;
   // Displacement taken as signed, as is usual for index offsets
   wire [15:0] disp_ext = {{8{disp[7]}}, disp};
   always_comb begin
      unique case (addr_mode)
         idx_plain, idx_post_inc: eff_addr = idx_pair;
         idx_disp: eff_addr = idx_pair + disp_ext;
         idx_plus_c: eff_addr = idx_pair + {8'h00, reg_c};
         idx_pre_dec: eff_addr = idx_dec;
         ptr_plain: eff_addr = ptr_pair;
         default: eff_addr = idx_pair;
      endcase
   end
   wire step_inc = addr_step && (addr_mode == idx_post_inc);
   wire step_dec = addr_step && (addr_mode == idx_pre_dec);
   wire [15:0] idx_next = step_inc ? idx_inc : idx_dec;

   ////////////////////////////////////////////////////////////////////////
   // Divider: accumulator pair by C
   // Divide is single cycle, which costs a wide combinational
   // divider but keeps the execution side free of wait states.
   // A zero divisor is caught before the divide so that no
   // undefined result reaches the flags or the array.
   wire div_zero = (reg_c == 8'h00);
   wire [15:0] quot = div_zero ? 16'hffff : acc_pair / {8'h00, reg_c};
   wire [15:0] remw = div_zero ? 16'h0000 : acc_pair % {8'h00, reg_c};
   wire div_bad = div_zero || (quot[15:8] != 8'h00);
   assign div_error = div_bad;

   ////////////////////////////////////////////////////////////////////////
   // Flag next values
   // Priority, lowest first: execution op, forced jump flag,
   // status word memory write, then return restore.
   // A return overrides everything, since the popped word must come
   // back whole regardless of what the last instruction did.
   logic zf_d;
   logic cf_d;
   logic hf_d;
   logic jf_d;
   always_comb begin
      zf_d = zf_q;
      cf_d = cf_q;
      hf_d = hf_q;
      jf_d = jf_q;
      unique case (flag_req.op)
         fl_none: ;
         fl_add8, fl_sub8: begin
            zf_d = (flag_req.result[7:0] == 8'h00);
            cf_d = flag_req.result[8];
            hf_d = flag_req.half_carry;
            jf_d = flag_req.jf_from_carry ? flag_req.result[8] : zf_d;
         end
         fl_add16, fl_sub16: begin
            zf_d = (flag_req.result[15:0] == 16'h0000);
            cf_d = flag_req.result[16];
            jf_d = flag_req.jf_from_carry ? flag_req.result[16] : zf_d;
         end
         fl_transfer: begin
            zf_d = (flag_req.result[7:0] == 8'h00);
            jf_d = 1'b1;
         end
         fl_logic: begin
            zf_d = (flag_req.result[7:0] == 8'h00);
            jf_d = zf_d;
         end
         fl_bitop: begin
            zf_d = ~flag_req.bit_val;
            jf_d = zf_d;
         end
         fl_mul: begin
            zf_d = (flag_req.result[15:8] == 8'h00);
            jf_d = zf_d;
         end
         fl_div: begin
            zf_d = (remw[7:0] == 8'h00);
            cf_d = div_bad;
            jf_d = zf_d;
         end
         fl_shift: begin
            cf_d = flag_req.bit_val;
            zf_d = (flag_req.result[7:0] == 8'h00);
            jf_d = cf_d;
         end
         fl_cf_bool: begin
            unique case (flag_req.cf_op)
               cb_load: cf_d = flag_req.bit_val;
               cb_xor: cf_d = cf_q ^ flag_req.bit_val;
               cb_store: cf_d = cf_q;
               cb_set: cf_d = 1'b1;
               cb_clear: cf_d = 1'b0;
               cb_cpl: cf_d = ~cf_q;
               default: cf_d = cf_q;
            endcase
         end
         default: ;
      endcase
      // Other instructions that force the jump flag
      if (flag_req.set_jf) begin
         jf_d = 1'b1;
      end
      // Status word memory write forces the jump flag; only a return overrides it
      if (psw_mem_wr) begin
         jf_d = 1'b1;
      end
      // Return restores the whole word, overriding execution updates
      if (psw_req.ret_restore) begin
         {jf_d, zf_d, cf_d, hf_d} = psw_req.pop_data[7:4];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bank selector next value
   // Priority, lowest first: bank load, memory write, return.
   // Only the low nibble of a memory write reaches the selector;
   // the flag nibble of the data is dropped.
   logic [3:0] bank_d;
   always_comb begin
      bank_d = bank_q;
      if (psw_req.ld_bank) begin
         bank_d = psw_req.bank_imm;
      end
      if (psw_mem_wr) begin
         bank_d = mem_req.wdata[3:0];
      end
      if (psw_req.ret_restore) begin
         bank_d = psw_req.pop_data[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flags: reset forces only the jump flag, the rest keep state
   // Zero, carry and half carry are left unreset on purpose so that
   // software can inspect them after a reset; they start unknown at
   // power up and must be set before first use.
   // The jump flag comes out of reset set, so a true jump is taken.
   always_ff @(posedge core_clk) begin
      jf_q <= rst ? 1'b1 : jf_d;
      zf_q <= zf_d;
      cf_q <= cf_d;
      hf_q <= hf_d;
   end

   // Bank selector
   // Synchronous reset to bank zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bank_q <= `BANK_SEL_RESET;
      end else begin
         bank_q <= bank_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register array writes; later writes in this list win on collisions
   // Collisions arise when any two of these write sources hit the
   // same byte in one cycle, which a well formed instruction never
   // does; the fixed order keeps the result defined all the same.
   // Divide results come last since they use two array bytes.
   // Register writes address the bank current before this edge; memory writes use the address.
   wire [6:0] w8_idx = cur_idx(bank_q, reg_req.sel8);
   wire [6:0] w16_hi = cur_idx(bank_q, pair_hi(reg_req.sel16));
   wire [6:0] w16_lo = cur_idx(bank_q, pair_hi(reg_req.sel16) + 3'h1);
   wire [6:0] h_idx = cur_idx(bank_q, `REG_H);
   wire [6:0] l_idx = cur_idx(bank_q, `REG_L);
   wire [6:0] w_idx = cur_idx(bank_q, `REG_W);
   wire [6:0] a_idx = cur_idx(bank_q, `REG_A);
   // Contents are unknown after power up, so no reset here
   always_ff @(posedge core_clk) begin
      if (mem_req.wr && in_banks) begin
         regs_q[mem_idx] <= mem_req.wdata;
      end
      if (reg_req.wr8) begin
         regs_q[w8_idx] <= reg_req.d8;
      end
      if (reg_req.wr16) begin
         regs_q[w16_hi] <= reg_req.d16[15:8];
         regs_q[w16_lo] <= reg_req.d16[7:0];
      end
      if (step_inc || step_dec) begin
         regs_q[h_idx] <= idx_next[15:8];
         regs_q[l_idx] <= idx_next[7:0];
      end
      if (div_go) begin
         regs_q[w_idx] <= remw[7:0];
         regs_q[a_idx] <= quot[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Memory read path, one cycle latency
   // Read data is held for one cycle only and is zero otherwise,
   // so the memory bus can OR this block with its neighbours.
   // The status word read sees the flags before this cycle's update.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (mem_req.rd && is_psw) begin
         rdata_q <= flags_word;
      end else if (mem_req.rd && in_banks) begin
         rdata_q <= regs_q[mem_idx];
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign mem_rdata = rdata_q;
   assign mem_hit = in_banks || is_psw;

   ////////////////////////////////////////////////////////////////////////
   // Status word outputs and jump condition
   // The half carry flag has no jump condition on purpose; it only
   // serves decimal adjustment.
   // Unused condition codes never jump.
   // The push data is the live word, taken on interrupt acceptance;
   // the partner stores it ahead of the program counter bytes.
   // Conditions read registered flags, never this cycle's update.
   assign status_word = flags_word;
   // Pushed before program counter bytes, so the partner takes it first
   assign psw_push_data = flags_word;
   assign bank_selector = bank_q;
   always_comb begin
      unique case (jump_cond)
         jc_true: jump_taken = jf_q;
         jc_false: jump_taken = ~jf_q;
         jc_zero: jump_taken = zf_q;
         jc_nzero: jump_taken = ~zf_q;
         jc_carry: jump_taken = cf_q;
         jc_ncarry: jump_taken = ~cf_q;
         default: jump_taken = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// file: testbench/bank_regs_asserts.sv
// Checker for the banked register file ports
`default_nettype none
module bank_regs_asserts (
   input wire logic core_clk,
   input wire logic rst,
   input wire bank_regs_pkg::mem_req_t mem_req,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_hit,
   input wire bank_regs_pkg::flag_req_t flag_req,
   input wire bank_regs_pkg::psw_req_t psw_req,
   input wire logic [7:0] status_word,
   input wire logic [7:0] psw_push_data,
   input wire logic [3:0] bank_selector
);
   timeunit 1ns;
   timeprecision 1ps;
   import bank_regs_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   //////////
   // Status write that no return overrides
   sequence s_psw_wr;
      mem_req.wr && mem_req.addr == 16'h003f && !psw_req.ret_restore;
   endsequence
   // Lone 8-bit add on the flags
   sequence s_add8;
      flag_req.op == fl_add8 && !flag_req.set_jf && !psw_req.ret_restore && !mem_req.wr;
   endsequence
   // Reset is checked on its own edge, so no disable
   property p_rst;
      disable iff (1'b0) rst |=> bank_selector == 4'h0 && status_word[7];
   endproperty
   property p_fmt;
      status_word[3:0] == bank_selector && psw_push_data[3:0] == bank_selector;
   endproperty
   property p_hit;
      mem_hit == (mem_req.addr >= 16'h003f && mem_req.addr <= 16'h00bf);
   endproperty
   property p_psw_wr;
      s_psw_wr |=> bank_selector == $past(mem_req.wdata[3:0]) && status_word[7];
   endproperty
   // Flags ignore the written data
   property p_keep;
      s_psw_wr ##0 (flag_req.op == fl_none && !flag_req.set_jf) |=> $stable(status_word[6:4]);
   endproperty
   property p_rd;
      mem_req.rd && !mem_req.wr && mem_req.addr == 16'h003f |=> mem_rdata == $past(status_word);
   endproperty
   property p_ld;
      psw_req.ld_bank && !mem_req.wr && !psw_req.ret_restore |=> bank_selector == $past(psw_req.bank_imm);
   endproperty
   property p_ret;
      psw_req.ret_restore |=> status_word == $past(psw_req.pop_data);
   endproperty
   property p_add8;
      s_add8 |=> status_word[6:4] == {$past(flag_req.result[7:0]) == 8'h00,
         $past(flag_req.result[8]), $past(flag_req.half_carry)};
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   a_fmt: assert property (p_fmt) else $error("bank field wrong");
   a_hit: assert property (p_hit) else $error("map decode wrong");
   a_psw_wr: assert property (p_psw_wr) else $error("status write wrong");
   a_keep: assert property (p_keep) else $error("flags took data");
   a_rd: assert property (p_rd) else $error("status read wrong");
   a_ld: assert property (p_ld) else $error("bank load wrong");
   a_ret: assert property (p_ret) else $error("restore wrong");
   a_add8: assert property (p_add8) else $error("add flags wrong");
endmodule
bind banked_regs_and_status_word bank_regs_asserts chk_u (
   .core_clk, .rst, .mem_req, .mem_rdata, .mem_hit, .flag_req,
   .psw_req, .status_word, .psw_push_data, .bank_selector
);
`default_nettype wire

// file: testbench/stack_model.sv
// Interrupt stack beside the core
`default_nettype none
module stack_model (
   input wire logic core_clk,
   input wire logic push,
   input wire logic pop,
   input wire logic [7:0] psw_in,
   input wire logic [15:0] pc,
   output logic [7:0] psw_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem_q [0:63]; // Stack bytes
   int sp_q = 0; // Next free byte
   // Frame: status first, then pc high, pc low
   always @(posedge core_clk) begin
      if (push) begin
         mem_q[sp_q] <= psw_in;
         mem_q[sp_q + 1] <= pc[15:8];
         mem_q[sp_q + 2] <= pc[7:0];
         sp_q <= sp_q + 3;
      end else if (pop && sp_q >= 3) begin
         sp_q <= sp_q - 3;
      end
   end
   // Status comes off last, under the pc bytes
   assign psw_out = (sp_q >= 3) ? mem_q[sp_q - 3] : 8'h00;
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Directed bench for the banked register file
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import bank_regs_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   mem_req_t mem_req = '0;
   reg_req_t reg_req = '0;
   flag_req_t flag_req = '0;
   psw_req_t psw_req;
   logic [2:0] rd_sel8 = 3'h0;
   pair_sel_t rd_sel16 = pair_acc;
   addr_mode_t addr_mode = idx_plain;
   logic [7:0] disp = 8'hfe; // Negative displacement
   logic addr_step = 1'b0;
   logic div_go = 1'b0;
   jump_cond_t jump_cond = jc_true;
   logic irq = 1'b0, ret = 1'b0, ldb = 1'b0;
   logic [3:0] imm = 4'h0;
   logic [7:0] mem_rdata, rd_data8, status_word, psw_push_data, pop_d;
   logic [15:0] rd_data16, eff_addr;
   logic [3:0] bank_selector;
   logic mem_hit, div_error, jump_taken;
   int fails = 0, cmp_count = 0, cycles = 0;
   assign psw_req = '{irq, ret, pop_d, ldb, imm};
   banked_regs_and_status_word dut_u (
      .core_clk, .rst, .mem_req, .mem_rdata, .mem_hit, .reg_req, .rd_sel8,
      .rd_data8, .rd_sel16, .rd_data16, .addr_mode, .disp, .addr_step, .eff_addr,
      .div_go, .div_error, .flag_req, .psw_req, .status_word, .psw_push_data,
      .bank_selector, .jump_cond, .jump_taken
   );
   stack_model stack_u (
      .core_clk, .push(irq), .pop(ret), .psw_in(psw_push_data), .pc(16'h1234), .psw_out(pop_d)
   );
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   //////////
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Hang guard, well past the directed run
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         stop_test();
      end
   end
   // One memory access; read data lands on the second edge
   task automatic mem(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      mem_req <= '{!w, w, a, d};
      @(posedge core_clk);
      mem_req <= '0;
      #1;
   endtask
   task automatic wreg(input logic [2:0] s, input logic [7:0] d);
      @(posedge core_clk);
      reg_req <= '{1'b1, s, d, 1'b0, pair_acc, 16'h0000};
      @(posedge core_clk);
      reg_req <= '0;
      #1;
   endtask
   // Interrupt entry, return and bank load strobes
   task automatic ctl(input logic i, input logic r, input logic l, input logic [3:0] b);
      @(posedge core_clk);
      {irq, ret, ldb, imm} <= {i, r, l, b};
      @(posedge core_clk);
      {irq, ret, ldb} <= 3'h0;
      #1;
   endtask
   task automatic flg(input logic [16:0] r, input logic hc, input logic jc);
      @(posedge core_clk);
      flag_req <= '{fl_add8, r, hc, 1'b0, jc, cb_load, 1'b0};
      @(posedge core_clk);
      flag_req.op <= fl_none;
      #1;
   endtask
   // Any flag operation with a data bit and a carry operation
   task automatic fop(input flag_op_t op, input logic [16:0] r, input logic bv, input cf_op_t c);
      @(posedge core_clk);
      flag_req <= '{op, r, 1'b0, bv, 1'b0, c, 1'b0};
      @(posedge core_clk);
      flag_req.op <= fl_none;
      #1;
   endtask
   //////////
   task automatic t_reset();
      #1;
      chk("rst bank", 4'h0, bank_selector);
      chk("rst jf", 1'b1, status_word[7]);
      flg(17'h00100, 1'b1, 1'b0);
      chk("add flags", 3'h7, status_word[6:4]);
      ctl(1'b0, 1'b0, 1'b1, 4'h9);
      @(posedge core_clk);
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk("rerst status", 8'hf0, status_word);
   endtask
   task automatic t_psw();
      flg(17'h00001, 1'b0, 1'b1);
      chk("jf carry", 1'b0, status_word[7]);
      mem(1'b1, 16'h003f, 8'hfa);
      chk("psw write", 8'h8a, status_word);
      mem(1'b0, 16'h003f, 8'h00);
      chk("psw read", 8'h8a, mem_rdata);
   endtask
   // Lowest and highest bank, then a place past the map
   task automatic t_banks();
      logic [3:0] b;
      for (int n = 0; n < 2; n++) begin
         b = n[0] ? 4'hf : 4'h0;
         ctl(1'b0, 1'b0, 1'b1, b);
         for (int i = 0; i < 8; i++) begin
            wreg(i[2:0], {b, 1'b0, i[2:0]});
         end
         for (int i = 0; i < 8; i++) begin
            mem(1'b0, 16'h0040 + {b, i[2:0]}, 8'h00);
            chk("bank byte", {b, 1'b0, i[2:0]}, mem_rdata);
         end
         @(posedge core_clk);
         rd_sel16 <= pair_cnt;
         #1;
         chk("pair", {b, 4'h2, b, 4'h3}, rd_data16);
      end
      mem(1'b1, 16'h00bf, 8'h5a);
      @(posedge core_clk);
      rd_sel8 <= 3'h7;
      #1;
      chk("mem to reg", 8'h5a, rd_data8);
      mem(1'b0, 16'h00c0, 8'h00);
      chk("unmapped", 8'h00, mem_rdata);
   endtask
   task automatic t_div();
      @(posedge core_clk);
      rd_sel16 <= pair_acc;
      wreg(3'h0, 8'h01);
      wreg(3'h1, 8'h23);
      wreg(3'h3, 8'h10);
      chk("div ok", 1'b0, div_error);
      @(posedge core_clk);
      div_go <= 1'b1;
      @(posedge core_clk);
      div_go <= 1'b0;
      #1;
      chk("div result", 16'h0312, rd_data16);
      wreg(3'h3, 8'h00);
      chk("div zero", 1'b1, div_error);
      wreg(3'h0, 8'h12);
      wreg(3'h3, 8'h10);
      chk("div ovf", 1'b1, div_error);
   endtask
   task automatic t_idx();
      addr_mode_t m [6] = '{idx_plain, idx_disp, idx_plus_c, idx_post_inc, idx_pre_dec, ptr_plain};
      logic [15:0] e [6] = '{16'h0100, 16'h00fe, 16'h0110, 16'h0100, 16'h00ff, 16'h2030};
      wreg(3'h6, 8'h01);
      wreg(3'h7, 8'h00);
      wreg(3'h4, 8'h20);
      wreg(3'h5, 8'h30);
      for (int k = 0; k < 6; k++) begin
         @(posedge core_clk);
         addr_mode <= m[k];
         #1;
         chk("eff addr", e[k], eff_addr);
      end
      // Back to back steps: up then down
      @(posedge core_clk);
      addr_mode <= idx_post_inc;
      addr_step <= 1'b1;
      rd_sel16 <= pair_idx;
      @(posedge core_clk);
      addr_mode <= idx_pre_dec;
      @(posedge core_clk);
      addr_step <= 1'b0;
      #1;
      chk("stepped", 16'h0100, rd_data16);
      chk("pre dec", 16'h00ff, eff_addr);
   endtask
   task automatic t_irq();
      ctl(1'b0, 1'b0, 1'b1, 4'h3);
      flg(17'h00001, 1'b0, 1'b1);
      ctl(1'b1, 1'b0, 1'b0, 4'h0);
      ctl(1'b0, 1'b0, 1'b1, 4'h7);
      flg(17'h00100, 1'b1, 1'b0);
      chk("isr bank", 4'h7, bank_selector);
      ctl(1'b0, 1'b1, 1'b0, 4'h0);
      chk("restored", 8'h03, status_word);
   endtask
   // All flags clear, then all set: every decision flips
   task automatic t_jump();
      for (int p = 0; p < 2; p++) begin
         if (p == 1) begin
            flg(17'h00100, 1'b1, 1'b1);
         end
         for (int k = 0; k < 6; k++) begin
            @(posedge core_clk);
            jump_cond <= jump_cond_t'(k);
            #1;
            chk("jump", (k % 2 == 1) ^ p[0], jump_taken);
         end
      end
   endtask
   // Starts with all flags set; checks the flag nibble after each op
   task automatic t_flags();
      fop(fl_bitop, 17'h00000, 1'b1, cb_load);
      chk("bit op", 4'h3, status_word[7:4]);
      fop(fl_mul, 17'h00042, 1'b0, cb_load);
      chk("mul", 4'hf, status_word[7:4]);
      fop(fl_shift, 17'h00080, 1'b0, cb_load);
      chk("shift", 4'h1, status_word[7:4]);
      fop(fl_cf_bool, 17'h00000, 1'b1, cb_xor);
      chk("cf xor", 4'h3, status_word[7:4]);
      fop(fl_cf_bool, 17'h00000, 1'b0, cb_cpl);
      chk("cf cpl", 4'h1, status_word[7:4]);
      wreg(3'h0, 8'h00);
      wreg(3'h1, 8'h21);
      wreg(3'h3, 8'h10);
      fop(fl_div, 17'h00000, 1'b0, cb_load);
      chk("div rem", 4'h1, status_word[7:4]);
      wreg(3'h1, 8'h20);
      fop(fl_div, 17'h00000, 1'b0, cb_load);
      chk("div zero rem", 4'hd, status_word[7:4]);
      @(posedge core_clk);
      mem_req.addr <= 16'h003f;
      #1;
      chk("hit", 1'b1, mem_hit);
      @(posedge core_clk);
      mem_req <= '0;
      #1;
      chk("no hit", 1'b0, mem_hit);
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_psw();
      t_banks();
      t_div();
      t_idx();
      t_irq();
      t_jump();
      t_flags();
      stop_test();
   end
endmodule
`default_nettype wire
